// File: phy_bmc_defines.svh
// offsets, field positions, reset values and timing figures
// assumes inclusion by bare name from the package and the block
`ifndef PHY_BMC_DEFINES_SVH
`define PHY_BMC_DEFINES_SVH

// register byte address and bus widths
`define BMC_OFFSET 8'h80
`define BMC_ADDR_W 8
`define BMC_REG_W 16

// field positions inside the control word
`define BMC_SPEED_BIT 13
`define BMC_ANEG_BIT 12
`define BMC_PDOWN_BIT 11
`define BMC_ISO_BIT 10
`define BMC_RESTART_BIT 9
`define BMC_DUPLEX_BIT 8
`define BMC_COLTEST_BIT 7

// strap field layout: enable, speed, duplex
`define STRAP_W 3
`define STRAP_ANEG_BIT 2
`define STRAP_SPEED_BIT 1
`define STRAP_DUPLEX_BIT 0

// reset values before the strap is taken
`define BMC_ANEG_RST 1'b0
`define BMC_SPEED_RST 1'b0
`define BMC_DUPLEX_RST 1'b0
`define BMC_PDOWN_RST 1'b0
`define BMC_ISO_RST 1'b0
`define BMC_COLTEST_RST 1'b0
`define BMC_RESTART_RST 1'b0

// bus answers
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

// collision test timing, in bit times and cycles
`define CLK_PERIOD_NS 10
`define BIT_TIME_NS 10
`define COL_ASSERT_BITS 512
`define COL_RELEASE_BITS 4
`define COL_ASSERT_CYC ((`COL_ASSERT_BITS * `BIT_TIME_NS) / `CLK_PERIOD_NS)
`define COL_RELEASE_CYC ((`COL_RELEASE_BITS * `BIT_TIME_NS) / `CLK_PERIOD_NS)

`endif

// File: phy_bmc_pkg.sv
// types shared by the basic mode control block
// assumes the defines header sits in the same folder
`include "phy_bmc_defines.svh"

package phy_bmc_pkg;
  typedef logic [`BMC_REG_W-1:0] ctrl_word_t;
  typedef logic [`BMC_ADDR_W-1:0] reg_addr_t;
  typedef logic [1:0] axi_resp_t;
  typedef logic [`STRAP_W-1:0] strap_t;
endpackage : phy_bmc_pkg

// File: phy_basic_mode_control.sv
// basic mode control register of the integrated transceiver
// assumes one 100 MHz clock, an AXI4-Lite master on the same clock,
// a strap field and autoneg engine on the same clock, and an MII
// transmit enable that arrives from another domain
`timescale 1ns/1ps
`include "phy_bmc_defines.svh"

// Overview of operation
// R1: autoneg on: manual speed and duplex ignored
// R2: autoneg off: manual bits set speed, duplex
// R3: enable and duplex loaded from strap field
// R4: power down resets 0, 1 powers down
// R5: isolate resets 0, cuts MII, management stays
// R6: restart bit write restarts autonegotiation
// R7: restart ignored while autoneg disabled
// R8: restart reads 1, clears when initiated
// R9: writing restart 0 never aborts negotiation
// R10: manual duplex 1 full, 0 half
// R11: collision test: COL follows TXEN rising
// R12: COL drops after TXEN falls; resets 0
// R13: bits six to zero read zero
// R14: manual speed 1 is 100, 0 is 10
// R15: sixteen bits used, upper word reads zero
// R16: register decoded at offset 0x80, read/write
// R17: control bits read back last written value
module phy_basic_mode_control
  import phy_bmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration strap field
  input wire logic [2:0] autoneg_strap_select,
  // autonegotiation engine
  output logic autoneg_enable,
  output logic autoneg_restart_req,
  input wire logic autoneg_restart_ack,
  input wire logic autoneg_speed_100,
  input wire logic autoneg_full_duplex,
  // resolved operating mode
  output logic oper_speed_100,
  output logic oper_full_duplex,
  output logic power_down,
  output logic isolate,
  // mii side
  input wire logic mii_txen,
  input wire logic core_col,
  output logic mii_col,
  output logic mii_out_en
);

  ////////////////////////////////////////////////////////////////////
  // register state
  logic aneg_q, speed_q, duplex_q, pdown_q;
  logic iso_q, coltest_q, restart_q, strap_done_q;

  // bus state
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  reg_addr_t awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  axi_resp_t bresp_q, rresp_q;

  // collision test path
  logic txen_s1_q, txen_s2_q, col_q;

  // decode, lane strobes and read word
  logic wr_fire, wr_hit, rd_hit, lo_en, hi_en, restart_set;
  ctrl_word_t ctrl_word;

  ////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

  // address decode for the single control word
  always_comb
  begin
    wr_hit = 1'b0;
    if (awaddr_q == `BMC_OFFSET)
    begin
      wr_hit = 1'b1; // R16
    end
    rd_hit = 1'b0;
    if (s_axi_araddr[`BMC_ADDR_W-1:0] == `BMC_OFFSET)
    begin
      rd_hit = 1'b1; // R16
    end
  end

  // byte lanes carrying the sixteen used bits
  assign lo_en = wr_fire && wr_hit && wstrb_q[0];
  assign hi_en = wr_fire && wr_hit && wstrb_q[1];

  // capture address and data in either order
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (wr_fire)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[`BMC_ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, error on an unmapped address
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `AXI_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strap load one edge after reset release
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_q <= 1'b0;
    end
    else
    begin
      strap_done_q <= 1'b1;
    end
  end

  // mode bits: strap first, then software writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aneg_q <= `BMC_ANEG_RST;
      speed_q <= `BMC_SPEED_RST;
      duplex_q <= `BMC_DUPLEX_RST;
    end
    else if (!strap_done_q)
    begin
      aneg_q <= autoneg_strap_select[`STRAP_ANEG_BIT]; // R3
      speed_q <= autoneg_strap_select[`STRAP_SPEED_BIT];
      duplex_q <= autoneg_strap_select[`STRAP_DUPLEX_BIT]; // R3
    end
    else
    begin
      if (hi_en)
      begin
        aneg_q <= wdata_q[`BMC_ANEG_BIT]; // R17
        speed_q <= wdata_q[`BMC_SPEED_BIT]; // R14
        duplex_q <= wdata_q[`BMC_DUPLEX_BIT]; // R10
      end
    end
  end

  // power down, isolate and collision test bits
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdown_q <= `BMC_PDOWN_RST; // R4
      iso_q <= `BMC_ISO_RST; // R5
      coltest_q <= `BMC_COLTEST_RST; // R12
    end
    else
    begin
      if (hi_en)
      begin
        pdown_q <= wdata_q[`BMC_PDOWN_BIT]; // R4
        iso_q <= wdata_q[`BMC_ISO_BIT]; // R5
      end
      if (lo_en)
      begin
        coltest_q <= wdata_q[`BMC_COLTEST_BIT]; // R17
      end
    end
  end

  // restart request: a write of 1 with autoneg on sets it
  assign restart_set = hi_en && wdata_q[`BMC_RESTART_BIT] && aneg_q; // R7

  // self-clear on engine ack; set wins, writing 0 has no effect
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restart_q <= `BMC_RESTART_RST;
    end
    else if (restart_set)
    begin
      restart_q <= 1'b1; // R6
    end
    else if (autoneg_restart_ack)
    begin
      restart_q <= 1'b0; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read path
  always_comb
  begin
    ctrl_word = '0; // R13
    ctrl_word[`BMC_SPEED_BIT] = speed_q;
    ctrl_word[`BMC_ANEG_BIT] = aneg_q;
    ctrl_word[`BMC_PDOWN_BIT] = pdown_q;
    ctrl_word[`BMC_ISO_BIT] = iso_q;
    ctrl_word[`BMC_RESTART_BIT] = restart_q; // R8
    ctrl_word[`BMC_DUPLEX_BIT] = duplex_q;
    ctrl_word[`BMC_COLTEST_BIT] = coltest_q;
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // read answer one edge after the address is taken
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `AXI_RESP_OKAY;
      rdata_q <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      rdata_q <= rd_hit ? {16'h0000, ctrl_word} : 32'h0000_0000; // R15
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operating mode resolution
  assign autoneg_enable = aneg_q;
  assign autoneg_restart_req = restart_q; // R9
  assign oper_speed_100 = aneg_q ? autoneg_speed_100 : speed_q; // R1 R2 R14
  assign oper_full_duplex = aneg_q ? autoneg_full_duplex : duplex_q; // R1 R2 R10
  assign power_down = pdown_q; // R4
  assign isolate = iso_q;

  ////////////////////////////////////////////////////////////////////
  // transmit enable synchroniser
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txen_s1_q <= 1'b0;
      txen_s2_q <= 1'b0;
    end
    else
    begin
      txen_s1_q <= mii_txen;
      txen_s2_q <= txen_s1_q;
    end
  end

  // test collision: three edges each way, inside both bounds
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_q <= 1'b0;
    end
    else
    begin
      col_q <= coltest_q && txen_s2_q; // R11 R12
    end
  end

  // mii outputs, dropped while isolated
  assign mii_col = iso_q ? 1'b0 : (coltest_q ? col_q : core_col); // R5 R11
  assign mii_out_en = !iso_q; // R5

endmodule : phy_basic_mode_control

// File: phy_bmc_chk_sva.sv
// checker for the basic mode control register ports
// assumes binding into the block, one clock, active low reset
`timescale 1ns/1ps
module phy_bmc_chk
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic autoneg_enable,
  input wire logic autoneg_restart_req,
  input wire logic autoneg_restart_ack,
  input wire logic autoneg_speed_100,
  input wire logic autoneg_full_duplex,
  input wire logic oper_speed_100,
  input wire logic oper_full_duplex,
  input wire logic isolate,
  input wire logic mii_txen,
  input wire logic core_col,
  input wire logic mii_col,
  input wire logic mii_out_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // bus handshakes
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  chk_rd_reserved: assert property (rd_take |=> s_axi_rvalid &&
    s_axi_rdata[6:0] == 7'h00 && s_axi_rdata[31:14] == 18'h00000)
    else $error("read late or reserved bits set");
  // mode selection
  chk_aneg_ignore: assert property (autoneg_enable |->
    oper_speed_100 == autoneg_speed_100 &&
    oper_full_duplex == autoneg_full_duplex)
    else $error("mode not from engine");
  chk_manual_hold: assert property (!autoneg_enable &&
    $past(rst_n, 2) && !$rose(s_axi_bvalid) |->
    $stable(oper_speed_100) && $stable(oper_full_duplex))
    else $error("manual mode moved without write");
  // restart bit
  chk_restart_gate: assert property ($rose(autoneg_restart_req) |->
    $past(autoneg_enable) && $rose(s_axi_bvalid))
    else $error("restart without enable or write");
  chk_restart_hold: assert property (autoneg_restart_req &&
    !autoneg_restart_ack |=> autoneg_restart_req)
    else $error("restart dropped early");
  chk_restart_clear: assert property (autoneg_restart_ack |=>
    !autoneg_restart_req || $rose(s_axi_bvalid))
    else $error("restart not cleared by ack");
  // mii side
  chk_iso_cut: assert property (mii_out_en == !isolate &&
    !(isolate && mii_col))
    else $error("isolate not cutting mii");
  chk_col_release: assert property (!mii_txen [*4] ##1 !core_col
    |-> !mii_col)
    else $error("collision held after transmit end");
endmodule : phy_bmc_chk

bind phy_basic_mode_control phy_bmc_chk u_phy_bmc_chk (.*);

// File: phy_basic_mode_control_tb_top.sv
// bench for the basic mode control register
// assumes the package, the block and its checker compiled first
`timescale 1ns/1ps
module phy_basic_mode_control_tb_top import phy_bmc_pkg::*;;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, autoneg_restart_ack, core_col;
  logic autoneg_speed_100, autoneg_full_duplex, mii_txen;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, autoneg_enable, autoneg_restart_req, isolate;
  logic oper_speed_100, oper_full_duplex, power_down, mii_col;
  logic mii_out_en;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  strap_t autoneg_strap_select;
  int fails, cmp_count, seed, m, n, i, k;
  phy_basic_mode_control u_phy_basic_mode_control (.*);
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      fails++;
      final_report();
    end
  endtask : tmo
  // bus master cycles
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    repeat (50)
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo(s_axi_bvalid);
    cmp(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    repeat (50)
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    tmo(s_axi_rvalid);
    rd_q = s_axi_rdata;
    cmp(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
  endtask : rd
  // model checks
  task automatic chkreg;
    rd(32'h80, 2'b00);
    cmp(rd_q, m);
    cmp({oper_speed_100, oper_full_duplex}, m[12] ?
      {autoneg_speed_100, autoneg_full_duplex} : {m[13], m[8]});
    cmp({power_down, isolate, mii_out_en, autoneg_enable,
      autoneg_restart_req}, {m[11], m[10], !m[10], m[12], m[9]});
    if (!m[7]) cmp(mii_col, core_col & !m[10]);
  endtask : chkreg
  // lane 1 carries bits 13..8, lane 0 carries bit 7
  task automatic wm(input int d, input logic [3:0] s = 4'hf);
    {autoneg_speed_100, autoneg_full_duplex, core_col} <=
      3'($random(seed));
    s_axi_wstrb <= s;
    wr(32'h80, d, 2'b00);
    k = {18'h0, {6{s[1]}}, s[0], 7'h0};
    m = (d & k & 32'h3d80) | (m & ~k & 32'h3d80) | (m & 32'h200)
      | (d & k & (m >> 3) & 32'h200);
    chkreg();
  endtask : wm
  task automatic wcol(input logic v, input int lim);
    for (n = 0; n < lim && mii_col !== v; n++) @(negedge sys_clk);
    cmp(mii_col, v);
  endtask : wcol
  ////////////////////////////////////////
  initial
  begin
    seed = 32'hf4167298;
    {fails, cmp_count, rst_n} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, autoneg_restart_ack, mii_txen, core_col} = 4'h0;
    {autoneg_speed_100, autoneg_full_duplex} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    autoneg_strap_select = strap_t'($random(seed));
    m = {autoneg_strap_select[1], autoneg_strap_select[2], 3'h0,
      autoneg_strap_select[0], 8'h00};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    chkreg();
    for (i = 0; i < 8; i++)
      wm(($random(seed) & 32'hffffefff) | 32'h200, 4'($random(seed)));
    wm(32'h1000);
    wm(32'h1200);
    wm(32'h1000);
    autoneg_restart_ack <= 1'b1;
    @(posedge sys_clk);
    autoneg_restart_ack <= 1'b0;
    m = m & 32'hfdff;
    chkreg();
    wr(32'h84, 32'hffffffff, 2'b10);
    rd(32'h84, 2'b10);
    cmp(rd_q, 32'h0);
    chkreg();
    wm(32'h80);
    mii_txen <= 1'b1;
    wcol(1'b1, 512);
    @(posedge sys_clk);
    mii_txen <= 1'b0;
    wcol(1'b0, 4);
    final_report();
  end
endmodule : phy_basic_mode_control_tb_top
